// *** hw/rcs_pkg.sv ***
// Package for the reset combiner and clock select block.
// Assumes a single 50 MHz core clock and an AHB-Lite register bus.
package rcs_pkg;

    // Register byte offsets
    localparam logic [7:0] RCS_OFF_SRC_EN   = 8'h00;
    localparam logic [7:0] RCS_OFF_CTRL     = 8'h04;
    localparam logic [7:0] RCS_OFF_STATUS   = 8'h08;
    localparam logic [7:0] RCS_OFF_CAUSE    = 8'h0c;

    // Source enable / cause bit positions
    localparam int RCS_SRC_SUPPLY    = 0;
    localparam int RCS_SRC_WATCHDOG  = 1;
    localparam int RCS_SRC_MISSCLK   = 2;
    localparam int RCS_SRC_COMPARE   = 3;
    localparam int RCS_SRC_SOFTWARE  = 4;
    localparam int RCS_SRC_CONVSTART = 5;
    localparam int RCS_SRC_PIN       = 6;
    localparam int RCS_NUM_SRC       = 7;

    // Control register bit positions
    localparam int RCS_CTRL_SWRST    = 0;
    localparam int RCS_CTRL_CLKSEL   = 1;
    localparam int RCS_CTRL_WDLOCK   = 2;

    // Status register bit positions
    localparam int RCS_STAT_CLKSEL   = 0;
    localparam int RCS_STAT_WDLOCK   = 1;
    localparam int RCS_STAT_RESET    = 2;

    // Reset values: software-disableable sources start enabled
    localparam logic [6:0] RCS_SRC_EN_RST = 7'h7f;
    localparam logic       RCS_CLK_INT    = 1'b0;

    // Power-on pulse driven out on the reset pin
    localparam int RCS_POR_NS     = 1000;
    localparam int RCS_CLK_NS     = 20;
    localparam int RCS_POR_CYCLES = (RCS_POR_NS + RCS_CLK_NS - 1) / RCS_CLK_NS;

    // AHB-Lite codes
    localparam logic [1:0] RCS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] RCS_HTRANS_SEQ    = 2'h3;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } rcs_bus_req_t;

    typedef struct packed {
        logic [6:0]  src_en;
        logic        clk_sel;
        logic        wd_lock;
        logic        sw_req;
        logic [6:0]  cause;
    } rcs_regs_t;

endpackage : rcs_pkg

// *** hw/rcs_por_stretch.sv ***
// Power-on pulse stretcher: holds its output for a fixed count after start.
// Assumes the core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rcs_por_stretch
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // Pulse
    output logic      o_active
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       active;
    } rcs_por_st_t;

    rcs_por_st_t st_r;
    rcs_por_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
        end
        st_nxt.active = (st_nxt.cnt != 8'h00);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_r.cnt    <= 8'(RCS_POR_CYCLES);
            st_r.active <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_active = st_r.active;

endmodule : rcs_por_stretch

// *** hw/rcs_top.sv ***
// Reset combiner and system clock select with an AHB-Lite register slave.
// Assumes all inputs synchronous to i_core_clk; i_rst_b is the power-on reset.
// The reset pin is open drain: o_rst_pin_oe high pulls it low.
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module rcs_top
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Reset sources
    input  wire logic        i_supply_monitor_enable_pin,
    input  wire logic        i_supply_low,
    input  wire logic        i_watchdog_rst,
    input  wire logic        i_missing_clk,
    input  wire logic        i_first_comparator_low,
    input  wire logic        i_conversion_start_pin,
    // Open-drain reset pin, active low
    input  wire logic        i_rst_pin_b,
    output logic             o_rst_pin_out,
    output logic             o_rst_pin_oe,
    // System outputs
    output logic             o_sys_rst,
    output logic             o_clk_sel_ext,
    output logic             o_wd_force_on
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        rcs_regs_t    regs;
        rcs_bus_req_t req;
        logic [31:0]  rdata;
        logic         sys_rst;
        logic         pin_oe;
    } rcs_state_t;

    rcs_state_t st_r;
    rcs_state_t st_nxt;
    logic       por_active;
    logic [6:0] src_raw;
    logic [6:0] src_act;

    rcs_por_stretch u_por (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .o_active   (por_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Source gating
    always_comb begin
        src_raw                    = '0;
        src_raw[RCS_SRC_SUPPLY]    = i_supply_low;
        src_raw[RCS_SRC_WATCHDOG]  = i_watchdog_rst;
        src_raw[RCS_SRC_MISSCLK]   = i_missing_clk;
        src_raw[RCS_SRC_COMPARE]   = i_first_comparator_low;
        src_raw[RCS_SRC_SOFTWARE]  = st_r.regs.sw_req;
        src_raw[RCS_SRC_CONVSTART] = i_conversion_start_pin;
        src_raw[RCS_SRC_PIN]       = ~i_rst_pin_b;
    end

    genvar g;
    generate
        for (g = 0; g < RCS_NUM_SRC; g++) begin : g_src
            if (g == RCS_SRC_SUPPLY) begin : g_sup
                assign src_act[g] = src_raw[g] & i_supply_monitor_enable_pin;
            end else if (g == RCS_SRC_PIN) begin : g_pin
                assign src_act[g] = src_raw[g];
            end else if (g == RCS_SRC_WATCHDOG) begin : g_wd
                // Lock overrides the enable bit
                assign src_act[g] = src_raw[g] & (st_r.regs.src_en[g] | st_r.regs.wd_lock);
            end else begin : g_gen
                assign src_act[g] = src_raw[g] & st_r.regs.src_en[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic take;
        logic [31:0] wd;
        take   = 1'b0;
        wd     = i_hwdata;
        st_nxt = st_r;

        take = i_hsel & i_hready & (i_htrans == RCS_HTRANS_NONSEQ || i_htrans == RCS_HTRANS_SEQ);
        st_nxt.req.sel   = take;
        st_nxt.req.write = i_hwrite;
        st_nxt.req.addr  = i_haddr[7:0];
        st_nxt.regs.sw_req = 1'b0;

        if (st_r.req.sel && st_r.req.write) begin
            case (st_r.req.addr)
                RCS_OFF_SRC_EN: begin
                    st_nxt.regs.src_en = wd[6:0];
                end
                RCS_OFF_CTRL: begin
                    st_nxt.regs.sw_req  = wd[RCS_CTRL_SWRST];
                    st_nxt.regs.clk_sel = wd[RCS_CTRL_CLKSEL];
                    // Sticky: only the power-on reset clears the lock
                    st_nxt.regs.wd_lock = st_r.regs.wd_lock | wd[RCS_CTRL_WDLOCK];
                end
                RCS_OFF_CAUSE: begin
                    // Write one to clear; new causes below win
                    st_nxt.regs.cause = st_r.regs.cause & ~wd[6:0];
                end
                default: begin
                end
            endcase
        end
        st_nxt.regs.cause = st_nxt.regs.cause | src_act;

        st_nxt.rdata = 32'h0000_0000;
        if (take && !i_hwrite) begin
            case (i_haddr[7:0])
                RCS_OFF_SRC_EN: st_nxt.rdata[6:0] = st_nxt.regs.src_en;
                RCS_OFF_CTRL: begin
                    st_nxt.rdata[RCS_CTRL_CLKSEL] = st_nxt.regs.clk_sel;
                    st_nxt.rdata[RCS_CTRL_WDLOCK] = st_nxt.regs.wd_lock;
                end
                RCS_OFF_STATUS: begin
                    st_nxt.rdata[RCS_STAT_CLKSEL] = st_r.regs.clk_sel;
                    st_nxt.rdata[RCS_STAT_WDLOCK] = st_r.regs.wd_lock;
                    st_nxt.rdata[RCS_STAT_RESET]  = st_r.sys_rst;
                end
                RCS_OFF_CAUSE:  st_nxt.rdata[6:0] = st_nxt.regs.cause;
                default:        st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Held while any source stays active; released one cycle after all clear
        st_nxt.sys_rst = (|src_act) | por_active;
        st_nxt.pin_oe  = por_active;

        // Clock select falls back to internal whenever reset is held
        if (st_nxt.sys_rst) begin
            st_nxt.regs.clk_sel = RCS_CLK_INT;
            st_nxt.regs.src_en  = RCS_SRC_EN_RST;
            st_nxt.regs.sw_req  = 1'b0;
            if (por_active) begin
                st_nxt.regs.wd_lock = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_r.regs.src_en  <= RCS_SRC_EN_RST;
            st_r.regs.clk_sel <= RCS_CLK_INT;
            st_r.regs.wd_lock <= 1'b0;
            st_r.regs.sw_req  <= 1'b0;
            st_r.regs.cause   <= 7'h00;
            st_r.req          <= '0;
            st_r.rdata        <= 32'h0000_0000;
            st_r.sys_rst      <= 1'b1;
            st_r.pin_oe       <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_hrdata      = st_r.rdata;
    assign o_hreadyout   = 1'b1;
    assign o_hresp       = 1'b0;
    assign o_rst_pin_out = 1'b0;
    assign o_rst_pin_oe  = st_r.pin_oe;
    assign o_sys_rst     = st_r.sys_rst;
    assign o_clk_sel_ext = st_r.regs.clk_sel;
    assign o_wd_force_on = st_r.regs.wd_lock;

endmodule : rcs_top

// *** bench/rcs_pin_model.sv ***
// Board side of the reset pin: pull-up plus a reset button.
// Assumes the device drives the pin open drain.
`timescale 1ns/100ps
module rcs_pin_model (
    input  wire logic i_oe,
    input  wire logic i_out,
    input  wire logic i_ext_rst,
    output logic      o_pin_b
);
    // A released pin rises to the pull-up, never holds a stale level
    assign o_pin_b = ~(i_ext_rst | (i_oe & ~i_out));
endmodule : rcs_pin_model

// *** bench/rcs_top_monitor.sv ***
// Port checker for rcs_top.
// Assumes the reset pin is read back on i_rst_pin_b.
`timescale 1ns/100ps
module rcs_top_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_supply_monitor_enable_pin,
    input wire logic        i_supply_low,
    input wire logic        i_rst_pin_b,
    input wire logic        o_rst_pin_out,
    input wire logic        o_rst_pin_oe,
    input wire logic        o_sys_rst,
    input wire logic        o_clk_sel_ext,
    input wire logic        o_wd_force_on
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////
    property p_sup; i_supply_monitor_enable_pin && i_supply_low |=> o_sys_rst; endproperty
    a_sup: assert property (p_sup) else $error("supply");
    property p_pin; !i_rst_pin_b |=> o_sys_rst; endproperty
    a_pin: assert property (p_pin) else $error("pin");
    property p_fell; $fell(o_sys_rst) |-> $past(i_rst_pin_b)
        && !($past(i_supply_low) && $past(i_supply_monitor_enable_pin)); endproperty
    a_fell: assert property (p_fell) else $error("early release");
    property p_por; $rose(i_rst_b) |-> o_rst_pin_oe [*8]; endproperty
    a_por: assert property (p_por) else $error("por out");
    property p_oe; o_rst_pin_oe |-> o_sys_rst && !o_rst_pin_out; endproperty
    a_oe: assert property (p_oe) else $error("pin drive");
    property p_clk; o_sys_rst |-> !o_clk_sel_ext; endproperty
    a_clk: assert property (p_clk) else $error("clock");
    property p_swap; $rose(o_clk_sel_ext) |-> $past(i_hwdata[1]) && !o_sys_rst; endproperty
    a_swap: assert property (p_swap) else $error("switch");
    // Only the power-on reset input may drop the lock; other resets keep it
    property p_lock; o_wd_force_on |=> o_wd_force_on; endproperty
    a_lock: assert property (p_lock) else $error("lock");
endmodule : rcs_top_monitor

bind rcs_top rcs_top_monitor mon_u (.*);

// *** bench/tb_rcs_top.sv ***
// Bench for rcs_top: AHB-Lite master, source drivers and pin model.
// Assumes a slave that may insert wait states; every phase waits on hready.
`timescale 1ns/100ps
module tb_rcs_top;
    import rcs_pkg::*;
    logic        clk, rst_b, hsel, hwrite, hrdy, hresp, mon_en;
    logic        pin_b, pin_out, oe, sys_rst, clk_ext, wd_on;
    logic [1:0]  htrans;
    logic [6:0]  src;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          error_cnt, total_checks;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    rcs_top dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_supply_monitor_enable_pin(mon_en), .i_supply_low(src[0]),
        .i_watchdog_rst(src[1]), .i_missing_clk(src[2]), .i_first_comparator_low(src[3]),
        .i_conversion_start_pin(src[5]), .i_rst_pin_b(pin_b), .o_rst_pin_out(pin_out),
        .o_rst_pin_oe(oe), .o_sys_rst(sys_rst), .o_clk_sel_ext(clk_ext),
        .o_wd_force_on(wd_on));
    rcs_pin_model pin_u (.i_oe(oe), .i_out(pin_out), .i_ext_rst(src[6]), .o_pin_b(pin_b));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic hang;
        error_cnt++;
        complete_run;
    endtask : hang

    task automatic rdy;
        int n = 0;
        do @(posedge clk); while (hrdy !== 1'b1 && ++n < 16);
        if (hrdy !== 1'b1) hang;
    endtask : rdy

    // Read data is taken at the edge that ends the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= RCS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
        chk(hresp, 1'b0);
    endtask : bus

    task automatic settle;
        int n = 0;
        do @(negedge clk); while (sys_rst !== 1'b0 && ++n < 80);
        if (sys_rst !== 1'b0) hang;
    endtask : settle

    // Source b active for a few cycles; index of software reset uses the bus
    task automatic hit(input int b, input logic e);
        logic s = 1'b0;
        if (b == RCS_SRC_SOFTWARE) begin
            bus(1'b1, RCS_OFF_CTRL, 32'h1);
        end else begin
            @(posedge clk);
            src[b] <= 1'b1;
        end
        repeat (4) begin
            @(negedge clk);
            s |= sys_rst;
        end
        @(posedge clk);
        src <= 7'h0;
        chk(s, e);
        settle;
    endtask : hit

    ////////////////////////////////////////////////////////////////
    task automatic t_por;
        int n = 0;
        @(negedge clk);
        chk({oe, sys_rst, clk_ext, pin_b}, 4'hc);
        while (oe === 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk(n > RCS_POR_CYCLES - 3 && n < RCS_POR_CYCLES + 3, 1'b1);
        settle;
        bus(1'b0, RCS_OFF_SRC_EN, 32'h0);
        chk(q, 32'h7f);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        $display("test power-on done");
    endtask : t_por

    task automatic t_src;
        for (int b = 1; b < 6; b++) begin
            hit(b, 1'b1);
            bus(1'b1, RCS_OFF_SRC_EN, 32'h7f ^ (32'h1 << b));
            hit(b, 1'b0);
        end
        @(posedge clk);
        mon_en <= 1'b0;
        hit(0, 1'b0);
        @(posedge clk);
        mon_en <= 1'b1;
        bus(1'b1, RCS_OFF_SRC_EN, 32'h3e);
        hit(6, 1'b1);
        bus(1'b1, RCS_OFF_SRC_EN, 32'h3e);
        hit(0, 1'b1);
        // Every one of the seven sources has fired once by now
        bus(1'b0, RCS_OFF_CAUSE, 32'h0);
        chk(q, 32'h7f);
        bus(1'b1, RCS_OFF_CAUSE, 32'h7f);
        bus(1'b0, RCS_OFF_CAUSE, 32'h0);
        chk(q, 32'h0);
        $display("test sources done");
    endtask : t_src

    task automatic t_clk;
        bus(1'b1, RCS_OFF_CTRL, 32'h2);
        bus(1'b0, RCS_OFF_STATUS, 32'h0);
        chk({q[2:0], clk_ext}, 4'h3);
        bus(1'b1, RCS_OFF_CTRL, 32'h0);
        bus(1'b0, RCS_OFF_STATUS, 32'h0);
        chk({q[2:0], clk_ext}, 4'h0);
        bus(1'b1, RCS_OFF_CTRL, 32'h2);
        hit(2, 1'b1);
        chk(clk_ext, 1'b0);
        $display("test clock select done");
    endtask : t_clk

    task automatic t_wd;
        bus(1'b1, RCS_OFF_CTRL, 32'h4);
        bus(1'b1, RCS_OFF_SRC_EN, 32'h7d);
        bus(1'b1, RCS_OFF_CTRL, 32'h0);
        @(negedge clk);
        chk(wd_on, 1'b1);
        hit(1, 1'b1);
        chk(wd_on, 1'b1);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        settle;
        chk(wd_on, 1'b0);
        chk(clk_ext, 1'b0);
        $display("test watchdog lock done");
    endtask : t_wd

    initial begin
        {rst_b, hsel, hwrite, htrans, src, haddr, hwdata} = '0;
        mon_en = 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_por;
        t_src;
        t_clk;
        t_wd;
        complete_run;
    end
endmodule : tb_rcs_top
